// ==== src/spseq_divider.sv ====
/*
  step divider: emits a one-cycle step pulse every STEP_CYCLES clocks while run is high.
  assumes run comes from logic on sys_clk.
*/
`include "spseq_params.svh"
module spseq_divider
#(
  parameter int STEP_CYCLES = `SPSEQ_STEP_CYCLES
)
(
  input  wire logic sys_clk,  // system clock
  input  wire logic reset_n,  // synchronous reset, active low
  input  wire logic run,      // count only while high
  output logic      step      // one-cycle step pulse
);
  logic [31:0] count_q;

  // a pulse instead of a derived clock keeps everything in one domain
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !run)
    begin
      count_q <= 32'h0;
      step    <= 1'b0;
    end
    // one step spans a power-on plus the hold-up capacitor recharge
    else if (count_q == 32'(STEP_CYCLES - 1)) // [R12]
    begin
      count_q <= 32'h0;
      step    <= 1'b1; // [R1]
    end
    else
    begin
      count_q <= count_q + 32'h1;
      step    <= 1'b0;
    end
  end

  a_step_spacing: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R1]
    step |=> !step)
    else $error("step pulse lasted more than one cycle");
endmodule

// ==== src/spseq_params.svh ====
/*
  constants for the staggered power-on sequencer: chain length and step timing.
  assumes a 100 MHz system clock; guarded so that several files can include it.
*/
// Operation
// [R1] divide system clock to a slow step clock covering one device power-on
// [R2] five flip-flops in a chain, each feeding the next, stepped together
// [R3] chain cleared until host user mode; stepping starts only from then
// [R4] each step moves a logic one one stage further along the chain
// [R5] first four stages each enable one downstream device power switch
// [R6] switch enables driven from the 3.3V io supply, above core plus threshold
// [R7] last stage drives active-low restart input, holding configuration off while low
// [R8] token at last stage releases restart high for downstream devices
// [R9] first downstream device loads from memory, then forwards along daisy chain
// [R10] shared complete line: open-drain from all but last, last drives actively
// [R11] complete line goes high only after every downstream device configured
// [R12] step period covers hold-up capacitor recharge plus one device power-on
// [R13] first stage input tied high; all stages then stay high until reset; the code also clears them when the host leaves user mode
`ifndef SPSEQ_PARAMS_SVH
`define SPSEQ_PARAMS_SVH

`define SPSEQ_STAGES        5
`define SPSEQ_SWITCHES      4
`define SPSEQ_CLK_PERIOD_NS 10
// one device power-on time plus capacitor recharge, in microseconds
`define SPSEQ_POWER_ON_US   5
`define SPSEQ_RECHARGE_US   5
`define SPSEQ_STEP_US       (`SPSEQ_POWER_ON_US + `SPSEQ_RECHARGE_US)
`define SPSEQ_STEP_CYCLES   ((`SPSEQ_STEP_US * 1000) / `SPSEQ_CLK_PERIOD_NS)

`endif

// ==== src/spseq_pkg.sv ====
/*
  types for the staggered power-on sequencer.
  assumes nothing beyond the params header.
*/
`include "spseq_params.svh"
package spseq_pkg;
  typedef logic [`SPSEQ_STAGES-1:0] spseq_chain_type;
  typedef enum logic [1:0]
  {
    SPSEQ_WAIT_type_unused = 2'h0
  } spseq_dummy_type;
  typedef enum logic [1:0]
  {
    SPSEQ_IDLE  = 2'h0,
    SPSEQ_STEP  = 2'h1,
    SPSEQ_DONE  = 2'h2
  } spseq_state_type;
endpackage

// ==== src/spseq_top.sv ====
/*
  staggered power-on sequencer: a token walks a five-stage chain, enabling four
  downstream power switches in turn, then releasing their configuration restart.
  assumes host_user_mode is an asynchronous pin level; switch pins sit on a 3.3V bank.
*/
`include "spseq_params.svh"
module spseq_top
  import spseq_pkg::*;
#(
  parameter int STEP_CYCLES = `SPSEQ_STEP_CYCLES
)
(
  input  wire logic                        sys_clk,         // system clock, 100 MHz
  input  wire logic                        reset_n,         // synchronous reset, active low
  input  wire logic                        host_user_mode,  // host configured, async level
  input  wire logic                        config_complete, // shared complete line, async
  output logic      [`SPSEQ_SWITCHES-1:0]  switch_en,       // power switch gates, 3.3V io
  output logic                             restart_n,       // downstream config restart, low
  output logic                             chain_user_mode  // downstream chain in user mode
);
  logic            user_meta_q;
  logic            user_sync_q;
  logic            done_meta_q;
  logic            done_sync_q;
  logic            step;
  logic            step_run;
  spseq_chain_type chain_q;
  spseq_state_type phase_q;
  spseq_state_type phase_d;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      user_meta_q <= 1'b0;
      user_sync_q <= 1'b0;
      done_meta_q <= 1'b0;
      done_sync_q <= 1'b0;
    end
    else
    begin
      user_meta_q <= host_user_mode;
      user_sync_q <= user_meta_q;
      done_meta_q <= config_complete;
      done_sync_q <= done_meta_q;
    end
  end

  spseq_divider #(.STEP_CYCLES(STEP_CYCLES)) u_divider
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .run     (step_run), // [R3]
    .step    (step)
  );

  // the divider rests once the walk is over, so nothing toggles while all stages hold
  assign step_run = user_sync_q && (phase_q != SPSEQ_DONE); // [R3]

  // the chain shifts on the step pulse, standing in for a divided clock
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !user_sync_q)
      chain_q <= '0; // [R3]
    else if (step)
      chain_q <= {chain_q[`SPSEQ_STAGES-2:0], 1'b1}; // [R2] [R4] [R13]
  end

  // outputs registered once more so pins come straight from flip-flops
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      switch_en       <= '0;
      restart_n       <= 1'b0;
      chain_user_mode <= 1'b0;
    end
    else
    begin
      switch_en       <= chain_q[`SPSEQ_SWITCHES-1:0]; // [R5] [R6]
      restart_n       <= chain_q[`SPSEQ_STAGES-1]; // [R7] [R8]
      // complete line is only meaningful once restart is released
      chain_user_mode <= done_sync_q && chain_q[`SPSEQ_STAGES-1]; // [R11]
    end
  end

  // phase of the walk: idle before user mode, stepping, then holding with all stages high
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      SPSEQ_IDLE:
      begin
        if (user_sync_q)
          phase_d = SPSEQ_STEP;
      end
      SPSEQ_STEP:
      begin
        if (!user_sync_q)
          phase_d = SPSEQ_IDLE;
        else if (chain_q[`SPSEQ_STAGES-1])
          phase_d = SPSEQ_DONE;
      end
      SPSEQ_DONE:
      begin
        // only the host leaving user mode ends the hold
        if (!user_sync_q)
          phase_d = SPSEQ_IDLE;
      end
      default:
        phase_d = SPSEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      phase_q <= SPSEQ_IDLE;
    else
      phase_q <= phase_d; // [R13]
  end

  // the checks below watch the walk from the synchroniser out to the pins
  sequence s_token_step;
    step ##1 1'b1;
  endsequence

  a_chain_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
    !user_sync_q |=> chain_q == '0)
    else $error("chain not cleared before user mode");

  a_token_advance: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R4]
    (user_sync_q && step) ##1 user_sync_q |-> chain_q == {$past(chain_q[3:0]), 1'b1})
    else $error("token did not advance by one stage");

  a_chain_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R13]
    (user_sync_q && !step) ##1 user_sync_q |-> $stable(chain_q))
    else $error("chain moved without a step");

  a_thermometer: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R2]
    ((chain_q + 5'h1) & chain_q) == 5'h0)
    else $error("chain stages not contiguous from first");

  a_switch_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R5]
    1'b1 |=> switch_en == $past(chain_q[3:0]))
    else $error("switch enables do not follow chain");

  a_restart_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R7]
    restart_n |-> switch_en == 4'hf)
    else $error("restart released before all switches on");

  a_restart_release: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R8]
    chain_q[4] |=> restart_n)
    else $error("restart not released after last stage");

  a_user_gate: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R11]
    chain_user_mode |-> $past(restart_n) || restart_n)
    else $error("user mode flagged while restart held");

  a_step_once: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R1]
    s_token_step |-> !step)
    else $error("step pulses back to back");

  // edges of the synchronised host level and of the restart release
  sequence s_user_rise;
    $rose(user_sync_q);
  endsequence

  sequence s_user_fall;
    $fell(user_sync_q);
  endsequence

  sequence s_restart_rise;
    $rose(restart_n);
  endsequence

  // the host level may reach the chain only through the second flip-flop
  a_sync_order: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
    s_user_rise |-> $past(user_meta_q))
    else $error("user mode bypassed the synchroniser");

  // chain clears one edge after the fall, the pins one edge later
  a_switch_clear: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
    s_user_fall |-> ##2 switch_en == 4'h0)
    else $error("switches not cleared after host left user mode");

  a_step_gated: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R3]
    step |-> $past(step_run))
    else $error("step pulse without run");

  a_restart_after: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R7]
    s_restart_rise |-> $past(switch_en) == 4'hf)
    else $error("restart released before all devices powered");

  a_walk_order: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R5]
    $rose(switch_en[3]) |-> $past(switch_en[2:0]) == 3'h7)
    else $error("last switch enabled out of order");

  a_user_done: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R11]
    chain_user_mode |-> $past(done_sync_q))
    else $error("user mode flagged without complete line");

  a_done_full: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R13]
    phase_q == SPSEQ_DONE |-> chain_q == 5'h1f)
    else $error("hold phase with chain not full");

  a_rest_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R1]
    phase_q == SPSEQ_DONE |-> !step)
    else $error("divider stepped after the walk ended");

  a_phase_legal: assert property (@(posedge sys_clk) disable iff (!reset_n) // [R2]
    phase_q inside {SPSEQ_IDLE, SPSEQ_STEP, SPSEQ_DONE})
    else $error("phase register holds an unused code");
endmodule

// ==== tb/spseq_downstream.sv ====
/*
  downstream devices: configure after restart release, then raise the complete line.
  assumes the sequencer powers all four devices before releasing restart.
*/
`include "spseq_params.svh"
module spseq_downstream
#(
  parameter int CFG_CYCLES = 6
)
(
  input  wire logic [`SPSEQ_SWITCHES-1:0] switch_en,       // power switch gates
  input  wire logic                       sys_clk,         // system clock
  input  wire logic                       restart_n,       // config restart, low
  output logic                            config_complete  // shared complete line
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // serial load then daisy-chain forwarding, seen only as a delay
  always @(negedge sys_clk)
    if (!restart_n || switch_en !== 4'hf) cnt <= 0;
    else if (cnt < CFG_CYCLES) cnt <= cnt + 1;
  // open-drain parts keep it low; the last part drives it once all are done
  assign config_complete = (cnt == CFG_CYCLES);
endmodule

// ==== tb/tb.sv ====
/*
  bench for the power-on sequencer: token order, spacing, hold and clear.
  assumes a step count shortened to 4 cycles.
*/
`include "spseq_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  logic                       sys_clk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       host_user_mode = 1'b0;
  logic                       config_complete;
  logic [`SPSEQ_SWITCHES-1:0] switch_en;
  logic                       restart_n;
  logic                       chain_user_mode;
  int                         error_cnt = 0;
  int                         checks = 0;
  always #5 sys_clk = ~sys_clk;
  spseq_top #(.STEP_CYCLES(STEP)) u_dut
  (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .host_user_mode  (host_user_mode),
    .config_complete (config_complete),
    .switch_en       (switch_en),
    .restart_n       (restart_n),
    .chain_user_mode (chain_user_mode)
  );
  spseq_downstream u_far
  (
    .switch_en       (switch_en),
    .sys_clk         (sys_clk),
    .restart_n       (restart_n),
    .config_complete (config_complete)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_change(input logic [4:0] prev, output int n);
    n = 0;
    while ({restart_n, switch_en} === prev && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // token walks out, one stage per step, then holds with the chain in user mode
  task automatic t_walk();
    logic [4:0] prev;
    int         n;
    prev = 5'h00;
    host_user_mode = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wait_change(prev, n);
      if (i > 0) check(8'(n), 8'(STEP));
      prev = {prev[3:0], 1'b1};
      check({3'h0, restart_n, switch_en}, {3'h0, prev});
    end
    n = 0;
    while (chain_user_mode !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h0, config_complete}, 8'h01);
    repeat (20) @(negedge sys_clk);
    check({2'h0, chain_user_mode, restart_n, switch_en}, 8'h3f);
  endtask
  // host leaving user mode clears everything and stops stepping
  task automatic t_clear();
    host_user_mode = 1'b0;
    repeat (5) @(negedge sys_clk);
    check({2'h0, chain_user_mode, restart_n, switch_en}, 8'h00);
    repeat (3 * STEP) @(negedge sys_clk);
    check({3'h0, restart_n, switch_en}, 8'h00);
  endtask
  // reset during the hold drops every output; the walk then restarts at the first stage
  task automatic t_reset();
    int n;
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({2'h0, chain_user_mode, restart_n, switch_en}, 8'h00);
    reset_n = 1'b1;
    wait_change(5'h00, n);
    check(8'(n), 8'(STEP + 4));
    check({3'h0, restart_n, switch_en}, 8'h01);
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    check({3'h0, restart_n, switch_en}, 8'h00);
    reset_n = 1'b1;
    t_walk();
    t_clear();
    t_walk();
    t_reset();
    close_out();
  end
  initial
  begin
    #20us;
    error_cnt++;
    close_out();
  end
endmodule
